// *** hw/srg_pkg.sv ***
// Purpose: Shared constants and types for the suspend/resume gating block
// Assumes: Core clock of 50 MHz; serial link sampled by that clock
// Notes: Resume latency figure is a plain default, override for real silicon
package srg_pkg;
	// ==========================================================
	// Opcodes
	localparam logic [7:0] OPC_SUSPEND = 8'hB0;
	localparam logic [7:0] OPC_RESUME = 8'hD0;
	// ==========================================================
	// Serial framing
	localparam int OPC_BITS = 8;
	localparam logic [3:0] BIT_CNT_FULL = 4'h8;
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
	localparam logic [3:0] BIT_CNT_ONE = 4'h1;
	localparam int SECTOR_W = 6;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESUME_LATENCY_NS = 10000;
	localparam int RESUME_CYCLES_I = (RESUME_LATENCY_NS / CLK_PERIOD_NS < 1) ? 1 : RESUME_LATENCY_NS / CLK_PERIOD_NS;
	localparam logic [15:0] RESUME_CYCLES = RESUME_CYCLES_I[15:0];
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	// ==========================================================
	// Operation kinds held by the sequencer
	typedef enum logic [1:0] {
		KIND_PROG1,
		KIND_PROG2,
		KIND_ERASE
	} srg_kind_e;
	// ==========================================================
	// Command classes presented by the command decoder
	typedef enum logic [3:0] {
		CLS_READ,
		CLS_BUF1_WRITE,
		CLS_BUF2_WRITE,
		CLS_PROG_ERASE,
		CLS_PROG_NOERASE,
		CLS_ERASE,
		CLS_PROTECT_MOD,
		CLS_PROTECT_READ,
		CLS_XFER1,
		CLS_XFER2,
		CLS_COMPARE,
		CLS_POWERDOWN,
		CLS_STATUS_READ,
		CLS_RESET
	} srg_class_e;
endpackage : srg_pkg

// *** hw/srg_sync.sv ***
// Purpose: Two flip-flop synchroniser for a group of independent levels
// Assumes: Each bit is a slow level relative to the clock
// Notes: First stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none
module srg_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	// ==========================================================
	// Synchroniser stages
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			stage1 <= '1;
			sync_o <= '1;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule : srg_sync
`default_nettype wire

// *** hw/srg_gate.sv ***
// Purpose: Suspend/resume control and command gating for the program/erase sequencer
// Assumes: Decoder presents a class per command; sequencer continues from saved context
// Notes: Serial link is sampled by mclk_i; opcode is the first byte after chip select falls
// Function
// - Refuse protection change, lockdown, freeze and security program while anything suspended.
// - Accept protection map, lockdown and security area reads during any suspend.
// - Refuse transfer into a buffer whose program is suspended; accept otherwise.
// - Accept memory-to-buffer compares in every suspend state.
// - Refuse deep and ultra-deep power-down entry and exit while suspended.
// - Accept configuration, status, identification reads and resets during suspend.
// - Resume is opcode D0h alone; later bytes before chip select release ignored.
// - Restart suspended operation only at chip select release, within resume latency.
// - Resumed operation continues from where it stopped, not from its start.
// - Resume clears the resumed operation's suspend flag to zero.
// - After resume, ready/busy shows busy.
// - With erase and program both suspended, first resume restarts the program only.
// - Suspend arriving while resume is in progress is ignored without state change.
// - Suspend is opcode B0h; at release suspend, set flag, report ready.
// - Program to a sector whose erase is suspended is aborted.
`timescale 1ns/1ns
`default_nettype none
module srg_gate (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	input wire logic cmd_req_i,
	input wire srg_pkg::srg_class_e cmd_class_i,
	input wire logic [srg_pkg::SECTOR_W-1:0] cmd_sector_i,
	output logic cmd_grant_o,
	output logic cmd_deny_o,
	input wire logic seq_active_i,
	input wire srg_pkg::srg_kind_e seq_kind_i,
	input wire logic [srg_pkg::SECTOR_W-1:0] seq_sector_i,
	output logic seq_suspend_o,
	output logic seq_resume_o,
	output srg_pkg::srg_kind_e seq_resume_kind_o,
	output logic buf1_program_suspended_flag_o,
	output logic buf2_program_suspended_flag_o,
	output logic erase_suspended_flag_o,
	output logic resuming_o,
	output logic ready_o
);
	import srg_pkg::*;

	logic [2:0] link_s;
	logic sclk_s, cs_n_s, mosi_s;
	logic sclk_q, cs_n_q;
	logic sclk_rise, cs_rise;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic opc_full, is_suspend, is_resume;
	logic any_susp, allow;
	logic [SECTOR_W-1:0] erase_sector;
	logic [15:0] res_cnt;
	logic soft_reset;

	// ==========================================================
	// Link synchronisers
	srg_sync #(.WIDTH(3)) u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.async_i({spi_sclk_i, spi_cs_n_i, spi_mosi_i}),
		.sync_o(link_s)
	);
	assign sclk_s = link_s[2];
	assign cs_n_s = link_s[1];
	assign mosi_s = link_s[0];

	// ==========================================================
	// Edge history of the synchronised link
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b1;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= sclk_s;
			cs_n_q <= cs_n_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_q;
	assign cs_rise = cs_n_s & ~cs_n_q;

	// ==========================================================
	// Opcode capture, first byte only; further bytes are dropped
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			bit_cnt <= BIT_CNT_ZERO;
			shift <= 8'h00;
		end else if (cs_n_s) begin
			bit_cnt <= BIT_CNT_ZERO;
		end else if (sclk_rise && bit_cnt != BIT_CNT_FULL) begin
			bit_cnt <= bit_cnt + BIT_CNT_ONE;
			shift <= {shift[OPC_BITS-2:0], mosi_s};
		end
	end
	assign opc_full = (bit_cnt == BIT_CNT_FULL);
	assign is_suspend = cs_rise && opc_full && shift == OPC_SUSPEND;
	assign is_resume = cs_rise && opc_full && shift == OPC_RESUME;

	// ==========================================================
	// Command gating against the present suspend state
	assign any_susp = buf1_program_suspended_flag_o | buf2_program_suspended_flag_o | erase_suspended_flag_o;
	always_comb begin
		allow = 1'b1;
		if (any_susp) begin
			unique case (cmd_class_i)
				CLS_READ, CLS_PROTECT_READ: allow = 1'b1;
				CLS_COMPARE: allow = 1'b1;
				CLS_STATUS_READ, CLS_RESET: allow = 1'b1;
				CLS_BUF1_WRITE, CLS_XFER1: allow = ~buf1_program_suspended_flag_o;
				CLS_BUF2_WRITE, CLS_XFER2: allow = ~buf2_program_suspended_flag_o;
				CLS_PROG_NOERASE: allow = erase_suspended_flag_o & ~buf1_program_suspended_flag_o
					& ~buf2_program_suspended_flag_o & (cmd_sector_i != erase_sector);
				CLS_PROTECT_MOD: allow = 1'b0;
				CLS_POWERDOWN: allow = 1'b0;
				CLS_PROG_ERASE, CLS_ERASE: allow = 1'b0;
				default: allow = 1'b0;
			endcase
		end
	end

	// Grant or deny one cycle after the request
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cmd_grant_o <= 1'b0;
			cmd_deny_o <= 1'b0;
		end else begin
			cmd_grant_o <= cmd_req_i & allow;
			cmd_deny_o <= cmd_req_i & ~allow;
		end
	end
	assign soft_reset = cmd_req_i && cmd_class_i == CLS_RESET;

	// ==========================================================
	// Suspend flags, suspend and resume strobes to the sequencer
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			buf1_program_suspended_flag_o <= 1'b0;
			buf2_program_suspended_flag_o <= 1'b0;
			erase_suspended_flag_o <= 1'b0;
			erase_sector <= '0;
			seq_suspend_o <= 1'b0;
			seq_resume_o <= 1'b0;
			seq_resume_kind_o <= KIND_PROG1;
		end else begin
			seq_suspend_o <= 1'b0;
			seq_resume_o <= 1'b0;
			if (soft_reset) begin
				// Reset aborts all suspended work
				buf1_program_suspended_flag_o <= 1'b0;
				buf2_program_suspended_flag_o <= 1'b0;
				erase_suspended_flag_o <= 1'b0;
			end else if (is_suspend && seq_active_i && res_cnt == CNT_ZERO) begin
				seq_suspend_o <= 1'b1;
				unique case (seq_kind_i)
					KIND_PROG1: buf1_program_suspended_flag_o <= 1'b1;
					KIND_PROG2: buf2_program_suspended_flag_o <= 1'b1;
					KIND_ERASE: begin
						erase_suspended_flag_o <= 1'b1;
						erase_sector <= seq_sector_i;
					end
					default: ;
				endcase
			end else if (is_resume) begin
				// Programs first, buffer one before two; erase waits until no program is suspended
				if (buf1_program_suspended_flag_o) begin
					buf1_program_suspended_flag_o <= 1'b0;
					seq_resume_o <= 1'b1;
					seq_resume_kind_o <= KIND_PROG1;
				end else if (buf2_program_suspended_flag_o) begin
					buf2_program_suspended_flag_o <= 1'b0;
					seq_resume_o <= 1'b1;
					seq_resume_kind_o <= KIND_PROG2;
				end else if (erase_suspended_flag_o) begin
					erase_suspended_flag_o <= 1'b0;
					seq_resume_o <= 1'b1;
					seq_resume_kind_o <= KIND_ERASE;
				end
				// Nothing suspended: no strobe, flags kept
			end
		end
	end

	// ==========================================================
	// Resume window; suspend is locked out while it runs
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			res_cnt <= CNT_ZERO;
		end else if (soft_reset) begin
			res_cnt <= CNT_ZERO;
		end else if (is_resume && any_susp) begin
			res_cnt <= RESUME_CYCLES;
		end else if (res_cnt != CNT_ZERO) begin
			res_cnt <= res_cnt - CNT_ONE;
		end
	end
	assign resuming_o = (res_cnt != CNT_ZERO);

	// Ready/busy: busy while the sequencer runs or a resume is under way
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ready_o <= 1'b1;
		end else begin
			ready_o <= ~(seq_active_i | resuming_o | seq_resume_o);
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	protect_deny_a: assert property (cmd_req_i && cmd_class_i == CLS_PROTECT_MOD && any_susp |=> cmd_deny_o && !cmd_grant_o)
		else $error("protection change granted during suspend");
	protread_ok_a: assert property (cmd_req_i && cmd_class_i == CLS_PROTECT_READ |=> cmd_grant_o)
		else $error("protection read refused");
	xfer_own_a: assert property (cmd_req_i && cmd_class_i == CLS_XFER1 |=> cmd_deny_o == $past(buf1_program_suspended_flag_o))
		else $error("buffer one transfer gating wrong");
	compare_ok_a: assert property (cmd_req_i && cmd_class_i == CLS_COMPARE |=> cmd_grant_o)
		else $error("compare refused");
	pwrdn_deny_a: assert property (cmd_req_i && cmd_class_i == CLS_POWERDOWN && any_susp |=> cmd_deny_o)
		else $error("power-down granted during suspend");
	status_ok_a: assert property (cmd_req_i && (cmd_class_i == CLS_STATUS_READ || cmd_class_i == CLS_RESET) |=> cmd_grant_o)
		else $error("status read or reset refused");
	resume_at_cs_a: assert property (seq_resume_o |-> $past(cs_rise) && $past(shift) == OPC_RESUME)
		else $error("resume strobe without chip select release");
	flag_clear_a: assert property (seq_resume_o |-> (seq_resume_kind_o == KIND_PROG1 ? !buf1_program_suspended_flag_o :
		seq_resume_kind_o == KIND_PROG2 ? !buf2_program_suspended_flag_o : !erase_suspended_flag_o))
		else $error("resumed flag not cleared");
	busy_after_a: assert property (seq_resume_o |=> !ready_o [*3])
		else $error("ready shown right after resume");
	prog_first_a: assert property (is_resume && erase_suspended_flag_o && (buf1_program_suspended_flag_o
		|| buf2_program_suspended_flag_o) && !soft_reset |=> seq_resume_kind_o != KIND_ERASE && erase_suspended_flag_o)
		else $error("erase resumed before program");
	susp_ignore_a: assert property (is_suspend && resuming_o && !soft_reset |=> !seq_suspend_o && $stable(any_susp))
		else $error("suspend acted on during resume");
	resume_idle_a: assert property (is_resume && !any_susp |=> !seq_resume_o && res_cnt != RESUME_CYCLES)
		else $error("resume acted on with nothing suspended");
endmodule : srg_gate
`default_nettype wire

// *** bench/srg_host.sv ***
// Purpose: Host serial controller model that clocks one command frame at a time
// Assumes: Mode 0, serial clock period of 160 ns, clock still outside frames
// Notes: After release the data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module srg_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	// ==========================================================
	// Idle pins
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// ==========================================================
	// One frame: opcode, optional trailing byte the device must ignore
	task automatic frame(input logic [7:0] op, input logic [7:0] extra, input logic with_extra);
		logic [15:0] bits;
		int n;
		bits = {op, extra};
		n = with_extra ? 16 : 8;
		cs_n_o <= 1'b0;
		#80;
		for (int i = 15; i > 15 - n; i--) begin
			mosi_o <= bits[i];
			#80;
			sclk_o <= 1'b1;
			#80;
			sclk_o <= 1'b0;
		end
		#80;
		cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o;
		#400;
	endtask : frame
endmodule : srg_host
`default_nettype wire

// *** bench/test_suspend_resume_gating.sv ***
// Purpose: Self-checking bench for the suspend/resume gate
// Assumes: Host model drives the serial pins; the bench plays the sequencer
// Notes: Grants and flags are compared with an integer model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module test_suspend_resume_gating;
	import srg_pkg::*;
	logic mclk_i, rst_n_i, cmd_req, seq_active, sclk, cs_n, mosi;
	logic grant, deny, susp, resm, f1_o, f2_o, fe_o, resuming, ready;
	srg_class_e cls;
	srg_kind_e kind, rkind;
	logic [SECTOR_W-1:0] csec, ssec;
	logic [31:0] lfsr;
	int n_errors, total_checks, f1, f2, fe, esec, res, cyc;
	logic go, done;
	srg_kind_e go_kind;
	// ==========================================================
	// Clock, design, host
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	srg_gate dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
		.cmd_req_i(cmd_req), .cmd_class_i(cls), .cmd_sector_i(csec), .cmd_grant_o(grant), .cmd_deny_o(deny),
		.seq_active_i(seq_active), .seq_kind_i(kind), .seq_sector_i(ssec), .seq_suspend_o(susp),
		.seq_resume_o(resm), .seq_resume_kind_o(rkind), .buf1_program_suspended_flag_o(f1_o),
		.buf2_program_suspended_flag_o(f2_o), .erase_suspended_flag_o(fe_o), .resuming_o(resuming), .ready_o(ready));
	srg_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
	// Sequencer stand-in: pauses and continues on the strobes
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			seq_active <= 1'b0;
			kind <= KIND_PROG1;
		end else if (susp || done) begin
			seq_active <= 1'b0;
		end else if (go) begin
			seq_active <= 1'b1;
			kind <= go_kind;
		end else if (resm) begin
			seq_active <= 1'b1;
			kind <= rkind;
		end
	end
	// Cycle count for the resume window check
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
	end
	// ==========================================================
	// Helpers
	function logic [31:0] next_rand();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
		return lfsr;
	endfunction : next_rand
	function automatic logic exp_grant(int c, logic [SECTOR_W-1:0] s);
		if (f1 + f2 + fe == 0)
			return 1'b1;
		case (srg_class_e'(c))
			CLS_READ, CLS_PROTECT_READ, CLS_COMPARE, CLS_STATUS_READ, CLS_RESET: return 1'b1;
			CLS_BUF1_WRITE, CLS_XFER1: return f1 == 0;
			CLS_BUF2_WRITE, CLS_XFER2: return f2 == 0;
			CLS_PROG_NOERASE: return fe == 1 && f1 == 0 && f2 == 0 && int'(s) != esec;
			default: return 1'b0;
		endcase
	endfunction : exp_grant
	task automatic stop_test();
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk_flags();
		`CHK(f1_o, f1 == 1)
		`CHK(f2_o, f2 == 1)
		`CHK(fe_o, fe == 1)
	endtask : chk_flags
	task automatic try_cmd(input int c, input logic [SECTOR_W-1:0] s);
		logic g;
		g = exp_grant(c, s);
		@(posedge mclk_i);
		cmd_req <= 1'b1;
		cls <= srg_class_e'(c);
		csec <= s;
		@(posedge mclk_i);
		cmd_req <= 1'b0;
		#1;
		`CHK(grant, g)
		`CHK(deny, !g)
	endtask : try_cmd
	task automatic all_cmds();
		for (int c = 0; c < 13; c++) begin
			void'(next_rand());
			try_cmd(c, lfsr[SECTOR_W-1:0]);
		end
		chk_flags();
	endtask : all_cmds
	task automatic cmd_frame(input logic [7:0] op, input logic extra);
		logic a;
		srg_kind_e k;
		a = seq_active;
		k = kind;
		void'(next_rand());
		host.frame(op, lfsr[7:0], extra);
		@(negedge mclk_i);
		if (op == OPC_SUSPEND && a && res == 0) begin
			if (k == KIND_PROG1)
				f1 = 1;
			else if (k == KIND_PROG2)
				f2 = 1;
			else begin
				fe = 1;
				esec = int'(ssec);
			end
			`CHK(ready, 1'b1)
		end else if (op == OPC_RESUME && f1 + f2 + fe > 0) begin
			if (f1 == 1)
				f1 = 0;
			else if (f2 == 1)
				f2 = 0;
			else
				fe = 0;
			res = cyc;
			`CHK(ready, 1'b0)
			`CHK(resuming, 1'b1)
		end else if (op == OPC_RESUME) begin
			`CHK(resuming, res != 0)
		end
		chk_flags();
	endtask : cmd_frame
	task automatic start_op(input srg_kind_e k, input logic [SECTOR_W-1:0] s);
		@(posedge mclk_i);
		go <= 1'b1;
		go_kind <= k;
		ssec <= s;
		@(posedge mclk_i);
		go <= 1'b0;
		@(posedge mclk_i);
	endtask : start_op
	// Host waits out the resume window before suspending again
	task automatic wait_resume();
		int i;
		for (i = 0; i < 600 && resuming !== 1'b0; i++)
			@(posedge mclk_i);
		`CHK(cyc - res > RESUME_CYCLES_I - 40 && cyc - res <= RESUME_CYCLES_I, 1'b1)
		res = 0;
	endtask : wait_resume
	// ==========================================================
	// Main sequence
	initial begin
		lfsr = 32'hF2029C98;
		{rst_n_i, cmd_req, go, done, csec, ssec} = '0;
		cls = CLS_READ;
		go_kind = KIND_PROG1;
		{f1, f2, fe, esec, res, n_errors, total_checks} = '0;
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		`CHK(ready, 1'b1)
		all_cmds();
		cmd_frame(OPC_RESUME, 1'b0);
		start_op(KIND_ERASE, 6'h05);
		cmd_frame(OPC_SUSPEND, 1'b1);
		all_cmds();
		try_cmd(int'(CLS_PROG_NOERASE), ssec);
		start_op(KIND_PROG1, 6'h2A);
		cmd_frame(OPC_SUSPEND, 1'b0);
		all_cmds();
		cmd_frame(OPC_RESUME, 1'b1);
		`CHK(kind, KIND_PROG1)
		cmd_frame(OPC_SUSPEND, 1'b0);
		`CHK(seq_active, 1'b1)
		wait_resume();
		@(posedge mclk_i);
		done <= 1'b1;
		@(posedge mclk_i);
		done <= 1'b0;
		repeat (3) @(posedge mclk_i);
		cmd_frame(OPC_RESUME, 1'b0);
		`CHK(kind, KIND_ERASE)
		wait_resume();
		start_op(KIND_PROG2, 6'h11);
		cmd_frame(OPC_SUSPEND, 1'b0);
		all_cmds();
		try_cmd(int'(CLS_RESET), 6'h00);
		{f1, f2, fe} = '0;
		#1;
		chk_flags();
		stop_test();
	end
	// Watchdog well beyond the expected run
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
endmodule : test_suspend_resume_gating
`default_nettype wire
